/* logic/dadc_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - terminal set to 3 or 4 goes active when running and abs freq exceeds threshold
// - threshold terminal goes inactive at or below threshold minus hysteresis
// - between threshold minus hysteresis and threshold, terminal keeps its level
// - both analog detectors watch one channel chosen by code 0..3, 3 expansion
// - levels default 20.00 and 50.00 percent, hysteresis 5.00 clamped to level
// - analog flag sets when the selected channel's percent exceeds its level
// - analog flag clears only below level minus hysteresis
// - braking enabled by setting 1 starts when bus voltage exceeds threshold
// - brake threshold 110.0 to 140.0 percent, 100.0 is 537V, default 125.0
// - brake transistor switched with duty 20 to 100 percent, 100 is always on
// - braking stops once bus voltage drops below a lower release value
// - set below lower limit: mode 0 run at lower limit, mode 1 stop
// - fan mode 0 runs fan from power-on continuously
// - fan mode 1 default starts on run, stops a minute after parameter state
// - fan mode 2 on above 45 C, off below 40 C, hold between
// - segment switch off gives 7-segment; on gives 5-segment above switch frequency
// - terminal mode with jog priority 1 enters jog even while running
// - jog priority 0 never moves directly from running to jog
// - rapid stop deceleration time default 1.00 s, 0..650.00, scaled by unit
// - deadband compensation off, mode 1 default, or mode 2
// - overmodulation factor 1.00 to 1.10, default 1.05, raises voltage ceiling
// - phase adjust setting 0 enables phase detection, 1 disables it
// - ramp time unit code 0 hundredths, 1 tenths, 2 whole seconds
module dadc_top #(
  parameter int unsigned TICK_CYC = dadc_pkg::DADC_TICK_CYC,
  parameter int unsigned FAN_HOLD_TICKS = dadc_pkg::DADC_FAN_HOLD_TICKS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] out_freq_abs,
  input wire logic running,
  input wire logic param_setting,
  input wire logic [2:0] term_a_func,
  input wire logic [2:0] term_b_func,
  input wire logic [15:0] freq_threshold_one,
  input wire logic [15:0] freq_hyst_one,
  input wire logic [15:0] freq_threshold_two,
  input wire logic [15:0] freq_hyst_two,
  input wire logic [1:0] analog_level_detect_sel,
  input wire logic [15:0] analog_in_one,
  input wire logic [15:0] analog_in_two,
  input wire logic [15:0] analog_in_three,
  input wire logic [15:0] analog_in_expansion,
  input wire logic [15:0] analog_level_one,
  input wire logic [15:0] analog_hyst_one,
  input wire logic [15:0] analog_level_two,
  input wire logic [15:0] analog_hyst_two,
  input wire logic dyn_brake_enable,
  input wire logic [15:0] dyn_brake_threshold,
  input wire logic [6:0] dyn_brake_duty,
  input wire logic [15:0] bus_volt_pct,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] lower_limit_freq,
  input wire logic lower_limit_mode,
  input wire logic [1:0] fan_mode_select,
  input wire logic [7:0] heatsink_temp,
  input wire logic pwm_segment_switch_enable,
  input wire logic [15:0] pwm_segment_switch_freq,
  input wire logic terminal_ctrl,
  input wire logic jog_priority_enable,
  input wire logic run_cmd,
  input wire logic jog_cmd,
  input wire logic [1:0] ramp_time_unit_select,
  input wire logic [15:0] rapid_stop_time,
  input wire logic [1:0] deadband_mode,
  input wire logic [15:0] overmod_factor,
  input wire logic phase_adjust_select,
  output logic term_a_out,
  output logic term_b_out,
  output logic analog_level_detect_one,
  output logic analog_level_detect_two,
  output logic brake_on,
  output logic brake_active,
  output logic [15:0] run_freq,
  output logic run_stop,
  output logic fan_on,
  output logic pwm_five_seg,
  output logic [1:0] run_state,
  output logic [31:0] rapid_stop_ms,
  output logic [1:0] deadband_sel,
  output logic [15:0] overmod_eff,
  output logic phase_detect_en
);
  import dadc_pkg::*;

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] fan_cnt;
    logic [6:0] pwm_cnt;
    logic brake_act;
    logic brake_out;
    logic fan;
    logic five_seg;
    dadc_run_e run;
    logic term_a;
    logic term_b;
    logic [15:0] rfreq;
    logic rstop;
    logic [31:0] rsms;
    logic [1:0] db;
    logic [15:0] ovm;
    logic phase_en;
  } dadc_top_s;
  dadc_top_s st_q, st_d;

  // threshold sample 0..3 are frequency one, frequency two, analog one, analog two
  dadc_hyst_if hif [4] ();
  logic [15:0] ain_sel;
  logic [15:0] ahyst1, ahyst2;
  logic [15:0] brk_thr, brk_rel;
  logic [6:0] duty;
  logic freq_threshold_detect_one, freq_threshold_detect_two;

  always_comb begin
    case (analog_level_detect_sel)
      2'h0: ain_sel = analog_in_one;
      2'h1: ain_sel = analog_in_two;
      2'h2: ain_sel = analog_in_three;
      default: ain_sel = analog_in_expansion;
    endcase
  end

  assign ahyst1 = (analog_hyst_one > analog_level_one) ? analog_level_one : analog_hyst_one;
  assign ahyst2 = (analog_hyst_two > analog_level_two) ? analog_level_two : analog_hyst_two;

  assign hif[0].tick = st_q.tick;
  assign hif[0].value = out_freq_abs;
  assign hif[0].level = freq_threshold_one;
  assign hif[0].release_lvl = (freq_hyst_one > freq_threshold_one) ? 16'h0000 : freq_threshold_one - freq_hyst_one;
  assign hif[1].tick = st_q.tick;
  assign hif[1].value = out_freq_abs;
  assign hif[1].level = freq_threshold_two;
  assign hif[1].release_lvl = (freq_hyst_two > freq_threshold_two) ? 16'h0000 : freq_threshold_two - freq_hyst_two;
  assign hif[2].tick = st_q.tick;
  assign hif[2].value = ain_sel;
  assign hif[2].level = analog_level_one;
  assign hif[2].release_lvl = analog_level_one - ahyst1;
  assign hif[3].tick = st_q.tick;
  assign hif[3].value = ain_sel;
  assign hif[3].level = analog_level_two;
  assign hif[3].release_lvl = analog_level_two - ahyst2;

  // frequency detectors clear at or below release; analog ones strictly below
  dadc_hyst #(.CLR_INCL(1'b1)) u_freq_threshold_detect_one (.clk_sys(clk_sys), .nrst(nrst), .hif(hif[0]));
  dadc_hyst #(.CLR_INCL(1'b1)) u_freq_threshold_detect_two (.clk_sys(clk_sys), .nrst(nrst), .hif(hif[1]));
  dadc_hyst #(.CLR_INCL(1'b0)) u_ald1 (.clk_sys(clk_sys), .nrst(nrst), .hif(hif[2]));
  dadc_hyst #(.CLR_INCL(1'b0)) u_ald2 (.clk_sys(clk_sys), .nrst(nrst), .hif(hif[3]));

  assign freq_threshold_detect_one = hif[0].flag & running;
  assign freq_threshold_detect_two = hif[1].flag & running;

  // out-of-range settings fall back to the nearest legal value
  assign brk_thr = (dyn_brake_threshold < DADC_BRK_MIN) ? DADC_BRK_MIN :
                   (dyn_brake_threshold > DADC_BRK_MAX) ? DADC_BRK_MAX : dyn_brake_threshold;
  assign brk_rel = brk_thr - DADC_BRK_REL_GAP;
  assign duty = (dyn_brake_duty < DADC_DUTY_MIN) ? DADC_DUTY_MIN :
                (dyn_brake_duty > DADC_DUTY_MAX) ? DADC_DUTY_MAX : dyn_brake_duty;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.tick_cnt >= TICK_CYC - 1) begin
      st_d.tick_cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h00000001;
    end
    st_d.pwm_cnt = (st_q.pwm_cnt >= DADC_DUTY_MAX - 7'h01) ? 7'h00 : st_q.pwm_cnt + 7'h01;
    if (st_q.tick) begin
      if (!dyn_brake_enable) begin
        st_d.brake_act = 1'b0;
      end else if (bus_volt_pct > brk_thr) begin
        st_d.brake_act = 1'b1;
      end else if (bus_volt_pct < brk_rel) begin
        st_d.brake_act = 1'b0;
      end
      case (fan_mode_select)
        DADC_FAN_POWER: st_d.fan = 1'b1;
        DADC_FAN_RUN: begin
          if (running) begin
            st_d.fan = 1'b1;
            st_d.fan_cnt = '0;
          end else if (param_setting && st_q.fan) begin
            if (st_q.fan_cnt >= FAN_HOLD_TICKS - 1) begin
              st_d.fan = 1'b0;
            end else begin
              st_d.fan_cnt = st_q.fan_cnt + 32'h00000001;
            end
          end
        end
        DADC_FAN_TEMP: begin
          if (heatsink_temp > DADC_FAN_ON_C) begin
            st_d.fan = 1'b1;
          end else if (heatsink_temp < DADC_FAN_OFF_C) begin
            st_d.fan = 1'b0;
          end
        end
        default: st_d.fan = 1'b1;
      endcase
      if (!pwm_segment_switch_enable) begin
        st_d.five_seg = 1'b0;
      end else if (out_freq_abs > pwm_segment_switch_freq) begin
        st_d.five_seg = 1'b1;
      end else if (out_freq_abs < pwm_segment_switch_freq) begin
        st_d.five_seg = 1'b0;
      end
      if (set_freq < lower_limit_freq) begin
        st_d.rfreq = lower_limit_mode ? 16'h0000 : lower_limit_freq;
        st_d.rstop = lower_limit_mode;
      end else begin
        st_d.rfreq = set_freq;
        st_d.rstop = 1'b0;
      end
    end
    st_d.brake_out = st_q.brake_act && (st_q.pwm_cnt < duty);
    st_d.term_a = ((term_a_func == DADC_MFO_FREQ_THRESHOLD_DETECT_ONE) && freq_threshold_detect_one) || ((term_a_func == DADC_MFO_FREQ_THRESHOLD_DETECT_TWO) && freq_threshold_detect_two);
    st_d.term_b = ((term_b_func == DADC_MFO_FREQ_THRESHOLD_DETECT_ONE) && freq_threshold_detect_one) || ((term_b_func == DADC_MFO_FREQ_THRESHOLD_DETECT_TWO) && freq_threshold_detect_two);
    case (st_q.run)
      DADC_RUN_IDLE: begin
        if (jog_cmd) begin
          st_d.run = DADC_RUN_JOG;
        end else if (run_cmd) begin
          st_d.run = DADC_RUN_NORMAL;
        end
      end
      DADC_RUN_NORMAL: begin
        if (terminal_ctrl && jog_priority_enable && jog_cmd) begin
          st_d.run = DADC_RUN_JOG;
        end else if (!run_cmd) begin
          st_d.run = DADC_RUN_IDLE;
        end
      end
      DADC_RUN_JOG: begin
        if (!jog_cmd) begin
          st_d.run = run_cmd ? DADC_RUN_NORMAL : DADC_RUN_IDLE;
        end
      end
      default: st_d.run = DADC_RUN_IDLE;
    endcase
    case (ramp_time_unit_select)
      DADC_UNIT_HUNDREDTH: st_d.rsms = {16'h0000, rapid_stop_time} * 32'h0000000A;
      DADC_UNIT_TENTH: st_d.rsms = {16'h0000, rapid_stop_time} * 32'h00000064;
      DADC_UNIT_SECOND: st_d.rsms = {16'h0000, rapid_stop_time} * 32'h000003E8;
      default: st_d.rsms = {16'h0000, rapid_stop_time} * 32'h0000000A;
    endcase
    st_d.db = (deadband_mode > DADC_DB_MODE2) ? DADC_DB_MODE1 : deadband_mode;
    st_d.ovm = (overmod_factor < DADC_OVM_MIN) ? DADC_OVM_MIN :
               (overmod_factor > DADC_OVM_MAX) ? DADC_OVM_MAX : overmod_factor;
    st_d.phase_en = ~phase_adjust_select;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.fan <= 1'b0;
      st_q.db <= DADC_DB_MODE1;
      st_q.ovm <= DADC_OVM_DEF;
      st_q.phase_en <= 1'b1;
      st_q.rsms <= 32'h000003E8;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      analog_level_detect_one <= 1'b0;
      analog_level_detect_two <= 1'b0;
    end else begin
      analog_level_detect_one <= hif[2].flag;
      analog_level_detect_two <= hif[3].flag;
    end
  end

  assign term_a_out = st_q.term_a;
  assign term_b_out = st_q.term_b;
  assign brake_on = st_q.brake_out;
  assign brake_active = st_q.brake_act;
  assign run_freq = st_q.rfreq;
  assign run_stop = st_q.rstop;
  assign fan_on = st_q.fan;
  assign pwm_five_seg = st_q.five_seg;
  assign run_state = st_q.run;
  assign rapid_stop_ms = st_q.rsms;
  assign deadband_sel = st_q.db;
  assign overmod_eff = st_q.ovm;
  assign phase_detect_en = st_q.phase_en;
endmodule

/* logic/dadc_pkg.sv */
package dadc_pkg;
  // frequencies in 0.01 Hz, percentages in 0.01 %, brake volts in 0.1 %, temperature in degrees C
  localparam int unsigned DADC_FREQ_W = 16;
  localparam int unsigned DADC_PCT_W = 16;
  localparam int unsigned DADC_TEMP_W = 8;
  localparam int unsigned DADC_CLK_HZ = 125000000;
  localparam int unsigned DADC_TICK_NS = 1000;
  localparam int unsigned DADC_TICK_CYC = (DADC_TICK_NS * (DADC_CLK_HZ / 1000000)) / 1000;
  localparam logic [1:0] DADC_FSEL_DEF = 2'h0;
  localparam logic [15:0] DADC_ALD1_LEVEL_DEF = 16'h07D0;
  localparam logic [15:0] DADC_ALD2_LEVEL_DEF = 16'h1388;
  localparam logic [15:0] DADC_ALD_HYST_DEF = 16'h01F4;
  localparam logic [15:0] DADC_BRK_MIN = 16'h044C;
  localparam logic [15:0] DADC_BRK_MAX = 16'h0578;
  localparam logic [15:0] DADC_BRK_DEF = 16'h04E2;
  localparam logic [15:0] DADC_BRK_REL_GAP = 16'h0032;
  localparam logic [6:0] DADC_DUTY_MIN = 7'h14;
  localparam logic [6:0] DADC_DUTY_MAX = 7'h64;
  localparam logic [7:0] DADC_FAN_ON_C = 8'h2D;
  localparam logic [7:0] DADC_FAN_OFF_C = 8'h28;
  localparam int unsigned DADC_FAN_HOLD_S = 60;
  localparam int unsigned DADC_FAN_HOLD_TICKS = DADC_FAN_HOLD_S * 1000000;
  localparam logic [15:0] DADC_PWM_SW_FREQ_DEF = 16'h05DC;
  localparam logic [15:0] DADC_RSTOP_DEF = 16'h0064;
  localparam logic [15:0] DADC_OVM_MIN = 16'h0064;
  localparam logic [15:0] DADC_OVM_MAX = 16'h006E;
  localparam logic [15:0] DADC_OVM_DEF = 16'h0069;
  localparam logic [2:0] DADC_MFO_FREQ_THRESHOLD_DETECT_ONE = 3'h3;
  localparam logic [2:0] DADC_MFO_FREQ_THRESHOLD_DETECT_TWO = 3'h4;
  typedef enum logic [1:0] {
    DADC_FAN_POWER = 2'h0,
    DADC_FAN_RUN = 2'h1,
    DADC_FAN_TEMP = 2'h2
  } dadc_fan_e;
  typedef enum logic [1:0] {
    DADC_UNIT_HUNDREDTH = 2'h0,
    DADC_UNIT_TENTH = 2'h1,
    DADC_UNIT_SECOND = 2'h2
  } dadc_unit_e;
  typedef enum logic [1:0] {
    DADC_DB_OFF = 2'h0,
    DADC_DB_MODE1 = 2'h1,
    DADC_DB_MODE2 = 2'h2
  } dadc_db_e;
  typedef enum logic [1:0] {
    DADC_RUN_IDLE = 2'h0,
    DADC_RUN_NORMAL = 2'h1,
    DADC_RUN_JOG = 2'h2
  } dadc_run_e;
endpackage

/* logic/dadc_hyst_if.sv */
`timescale 1ns/1ps
interface dadc_hyst_if;
  logic tick;
  logic [15:0] value;
  logic [15:0] level;
  logic [15:0] release_lvl;
  logic flag;
  modport ctl (output tick, output value, output level, output release_lvl, input flag);
  modport det (input tick, input value, input level, input release_lvl, output flag);
endinterface

/* logic/dadc_hyst.sv */
`timescale 1ns/1ps
// set when value exceeds level, clear at or below the release level with CLR_INCL set, strictly below it with CLR_INCL clear
module dadc_hyst #(
  parameter bit CLR_INCL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  dadc_hyst_if.det hif
);
  typedef struct packed {
    logic flag;
  } dadc_hst_s;
  dadc_hst_s st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (hif.tick) begin
      if (hif.value > hif.level) begin
        st_d.flag = 1'b1;
      end else if (CLR_INCL ? (hif.value <= hif.release_lvl) : (hif.value < hif.release_lvl)) begin
        st_d.flag = 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign hif.flag = st_q.flag;
endmodule

/* tb/dadc_top_chk.sv */
`timescale 1ns/1ps
module dadc_top_chk
  import dadc_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned FAN_HOLD_TICKS = 10
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] out_freq_abs,
  input wire logic running,
  input wire logic [2:0] term_a_func,
  input wire logic [15:0] freq_threshold_one,
  input wire logic [15:0] freq_hyst_one,
  input wire logic [1:0] analog_level_detect_sel,
  input wire logic [15:0] analog_in_one,
  input wire logic [15:0] analog_level_one,
  input wire logic dyn_brake_enable,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] lower_limit_freq,
  input wire logic lower_limit_mode,
  input wire logic [1:0] fan_mode_select,
  input wire logic pwm_segment_switch_enable,
  input wire logic jog_priority_enable,
  input wire logic [1:0] deadband_mode,
  input wire logic phase_adjust_select,
  input wire logic term_a_out,
  input wire logic analog_level_detect_one,
  input wire logic brake_active,
  input wire logic [15:0] run_freq,
  input wire logic fan_on,
  input wire logic pwm_five_seg,
  input wire logic [1:0] run_state,
  input wire logic [1:0] deadband_sel,
  input wire logic phase_detect_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // eight steady cycles span one tick plus the two-clock answer while TICK_CYC is at most 6, as with 4 in the testbench
  property p_thr_set;
    (term_a_func == 3'h3 && running && out_freq_abs > freq_threshold_one)[*8] |-> term_a_out;
  endproperty
  a_thr_set: assert property (p_thr_set) else $error("threshold terminal not active");
  property p_thr_clr;
    (term_a_func == 3'h3 && freq_threshold_one >= freq_hyst_one
      && out_freq_abs <= freq_threshold_one - freq_hyst_one)[*8] |-> !term_a_out;
  endproperty
  a_thr_clr: assert property (p_thr_clr) else $error("threshold terminal not released");
  property p_ald_set;
    (analog_level_detect_sel == 2'h0 && analog_in_one > analog_level_one)[*8] |-> analog_level_detect_one;
  endproperty
  a_ald_set: assert property (p_ald_set) else $error("analog flag not set");
  property p_brk_off;
    (!dyn_brake_enable)[*8] |-> !brake_active;
  endproperty
  a_brk_off: assert property (p_brk_off) else $error("brake active while disabled");
  property p_fan_pwr;
    (fan_mode_select == 2'h0)[*8] |-> fan_on;
  endproperty
  a_fan_pwr: assert property (p_fan_pwr) else $error("fan off in power-on mode");
  property p_pwm_7;
    (!pwm_segment_switch_enable)[*8] |-> !pwm_five_seg;
  endproperty
  a_pwm_7: assert property (p_pwm_7) else $error("five segment while switching off");
  property p_low_run;
    (!lower_limit_mode && set_freq < lower_limit_freq)[*8] |-> run_freq == lower_limit_freq;
  endproperty
  a_low_run: assert property (p_low_run) else $error("not running at lower limit");
  property p_jog_hold;
    run_state == DADC_RUN_NORMAL && !jog_priority_enable |=> run_state != DADC_RUN_JOG;
  endproperty
  a_jog_hold: assert property (p_jog_hold) else $error("jog entered from running");
  property p_db;
    1'h1 |=> deadband_sel == (($past(deadband_mode) == 2'h3) ? 2'h1 : $past(deadband_mode));
  endproperty
  a_db: assert property (p_db) else $error("deadband select wrong");
  property p_phase;
    1'h1 |=> phase_detect_en == !$past(phase_adjust_select);
  endproperty
  a_phase: assert property (p_phase) else $error("phase detect enable wrong");
endmodule

bind dadc_top dadc_top_chk #(.TICK_CYC(TICK_CYC), .FAN_HOLD_TICKS(FAN_HOLD_TICKS)) u_chk (.*);

/* tb/dadc_fw_model.sv */
`timescale 1ns/1ps
// firmware side: output frequency slews toward the commanded target
module dadc_fw_model (
  input wire logic clk_sys,
  input wire logic [15:0] tgt,
  output logic [15:0] out_freq_abs
);
  initial out_freq_abs = 16'h0000;
  always @(negedge clk_sys) begin
    if (out_freq_abs + 16'h01F4 < tgt) begin
      out_freq_abs <= out_freq_abs + 16'h01F4;
    end else if (out_freq_abs > tgt + 16'h01F4) begin
      out_freq_abs <= out_freq_abs - 16'h01F4;
    end else begin
      out_freq_abs <= tgt;
    end
  end
endmodule

/* tb/dadc_top_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module dadc_top_tb;
  import dadc_pkg::*;
  typedef struct {string n; int s; logic [31:0] e;} dadc_note_s;
  localparam int unsigned TK = 4;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic running = 1'h0, param_setting = 1'h0, dyn_brake_enable = 1'h0, lower_limit_mode = 1'h0;
  logic pwm_segment_switch_enable = 1'h0, terminal_ctrl = 1'h1, jog_priority_enable = 1'h0;
  logic run_cmd = 1'h0, jog_cmd = 1'h0, phase_adjust_select = 1'h1;
  logic [2:0] term_a_func = 3'h3, term_b_func = 3'h4;
  logic [1:0] analog_level_detect_sel = 2'h0, fan_mode_select = 2'h1, ramp_time_unit_select = 2'h2;
  logic [1:0] deadband_mode = 2'h2;
  logic [6:0] dyn_brake_duty = DADC_DUTY_MAX;
  logic [7:0] heatsink_temp = 8'h19;
  logic [15:0] tgt = 16'h0000, freq_threshold_one = 16'h0BB8, freq_hyst_one = 16'h00C8;
  logic [15:0] freq_threshold_two = 16'h07D0, freq_hyst_two = 16'h00C8, ain [4] = '{default: 16'h0000};
  logic [15:0] analog_level_one = DADC_ALD1_LEVEL_DEF, analog_level_two = DADC_ALD2_LEVEL_DEF;
  logic [15:0] analog_hyst_one = DADC_ALD_HYST_DEF, analog_hyst_two = DADC_ALD_HYST_DEF;
  logic [15:0] dyn_brake_threshold = DADC_BRK_DEF, bus_volt_pct = 16'h03E8, set_freq = 16'h07D0;
  logic [15:0] lower_limit_freq = 16'h0000, pwm_segment_switch_freq = DADC_PWM_SW_FREQ_DEF;
  logic [15:0] rapid_stop_time = 16'h0005, overmod_factor = DADC_OVM_MAX, out_freq_abs;
  wire logic [15:0] analog_in_one = ain[0];
  wire logic [15:0] analog_in_two = ain[1];
  wire logic [15:0] analog_in_three = ain[2];
  wire logic [15:0] analog_in_expansion = ain[3];
  logic term_a_out, term_b_out, analog_level_detect_one, analog_level_detect_two, brake_on, brake_active;
  logic run_stop, fan_on, pwm_five_seg, phase_detect_en;
  logic [15:0] run_freq, overmod_eff;
  logic [1:0] run_state, deadband_sel;
  logic [31:0] rapid_stop_ms;
  dadc_note_s q[$];
  dadc_note_s nt;
  int failures = 0, cmp_count = 0, seed = 42, bcnt = 0;
  logic [15:0] fv [6] = '{16'h0BB9, 16'h0B54, 16'h0AF0, 16'h07D0, 16'h0708, 16'h0BB8};
  logic [15:0] ovm [5] = '{16'h0063, 16'h0064, 16'h0069, 16'h006E, 16'h006F};
  logic [15:0] av [4] = '{16'h1389, 16'h0640, 16'h05DC, 16'h05DB};
  logic [15:0] bv [4] = '{16'h04E3, 16'h04B1, 16'h04B0, 16'h04AF};
  logic [6:0] dv [4] = '{7'h14, 7'h37, 7'h64, 7'h0A};
  logic [7:0] tv [4] = '{8'h2E, 8'h2A, 8'h27, 8'h2D};
  logic [5:0] jt [7] = '{6'h31, 6'h39, 6'h3E, 6'h35, 6'h24, 6'h11, 6'h1D};

  dadc_top #(.TICK_CYC(TK), .FAN_HOLD_TICKS(10)) uut (.*);
  dadc_fw_model fw (.clk_sys(clk_sys), .tgt(tgt), .out_freq_abs(out_freq_abs));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] got(input int s);
    case (s)
      0: return 32'(term_a_out);
      1: return 32'(term_b_out);
      2: return 32'(analog_level_detect_one);
      3: return 32'(analog_level_detect_two);
      4: return 32'(brake_active);
      5: return 32'(run_freq);
      6: return 32'(run_stop);
      7: return 32'(fan_on);
      8: return 32'(pwm_five_seg);
      9: return 32'(run_state);
      10: return rapid_stop_ms;
      11: return 32'(deadband_sel);
      12: return 32'(overmod_eff);
      13: return 32'(phase_detect_en);
      default: return 32'(bcnt);
    endcase
  endfunction

  // checks run just after the falling edge, before inputs changed there reach any register
  always @(negedge clk_sys) begin
    #1;
    while (q.size() > 0) begin
      nt = q.pop_front();
      `CHK(nt.n, nt.e, got(nt.s))
    end
  end

  task automatic note(input string n, input int s, input logic [31:0] e);
    q.push_back('{n, s, e});
  endtask

  task automatic go(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // wait for the frequency to arrive, then three tick periods to cover one tick plus the answer
  task automatic fset(input logic [15:0] v);
    int k = 0;
    tgt = v;
    while (out_freq_abs !== v && k < 200) begin
      go(1);
      k++;
    end
    if (k == 200) begin
      failures++;
      summarize();
    end
    go(3 * TK);
  endtask

  initial begin
    go(3);
    note("db_rst", 11, 1);
    note("ovm_rst", 12, 32'h69);
    note("ph_rst", 13, 1);
    note("rs_rst", 10, 1000);
    note("thr_rst", 0, 0);
    note("ald_rst", 2, 0);
    go(1);
    nrst = 1'h1;
    for (int i = 0; i < 4; i++) begin
      deadband_mode = 2'(i);
      phase_adjust_select = 1'(i);
      go(2);
      note("deadband", 11, (i == 3) ? 1 : i);
      note("phase", 13, (i % 2 == 0) ? 1 : 0);
    end
    for (int i = 0; i < 5; i++) begin
      overmod_factor = ovm[i];
      go(2);
      note("overmod", 12, (i == 0) ? DADC_OVM_MIN : (i == 4) ? DADC_OVM_MAX : ovm[i]);
    end
    for (int i = 0; i < 6; i++) begin
      ramp_time_unit_select = 2'(i % 3);
      rapid_stop_time = (i < 3) ? 16'hFDE8 : 16'($random(seed));
      go(2);
      note("rstop", 10, 32'(rapid_stop_time) * ((i % 3 == 0) ? 10 : (i % 3 == 1) ? 100 : 1000));
    end
    running = 1'h1;
    for (int i = 0; i < 6; i++) begin
      fset(fv[i]);
      note("thr_a", 0, (i < 2) ? 1 : 0);
      note("thr_b", 1, (i == 4) ? 0 : 1);
    end
    term_a_func = 3'h4;
    term_b_func = 3'h2;
    go(3 * TK);
    note("thr_a4", 0, 1);
    note("thr_b2", 1, 0);
    term_a_func = 3'h3;
    term_b_func = 3'h4;
    for (int s = 0; s < 4; s++) begin
      ain = '{default: 16'h0000};
      go(3 * TK);
      analog_level_detect_sel = 2'(s);
      for (int j = 0; j < 4; j++) ain[j] = 16'({$random(seed)} % 10001);
      ain[s] = 16'(3000 + {$random(seed)} % 1000);
      go(3 * TK);
      note("ald1", 2, 1);
      note("ald2", 3, 0);
    end
    for (int i = 0; i < 4; i++) begin
      ain[3] = av[i];
      go(3 * TK);
      note("ald1_h", 2, (i < 3) ? 1 : 0);
      note("ald2_h", 3, (i == 0) ? 1 : 0);
    end
    analog_hyst_one = 16'hFFFF;
    ain[3] = av[0];
    go(3 * TK);
    ain[3] = 16'h0000;
    go(3 * TK);
    note("ald1_clamp", 2, 1);
    analog_hyst_one = DADC_ALD_HYST_DEF;
    dyn_brake_enable = 1'h1;
    for (int i = 0; i < 4; i++) begin
      bus_volt_pct = bv[i];
      go(3 * TK);
      note("brake", 4, (i < 3) ? 1 : 0);
    end
    dyn_brake_threshold = 16'h03E8;
    bus_volt_pct = 16'h044D;
    go(3 * TK);
    note("brk_clamp", 4, 1);
    for (int i = 0; i < 4; i++) begin
      dyn_brake_duty = dv[i];
      go(100);
      bcnt = 0;
      repeat (100) begin
        go(1);
        bcnt += 32'(brake_on);
      end
      note("brk_duty", 14, (i == 3) ? 20 : dv[i]);
    end
    dyn_brake_enable = 1'h0;
    go(3 * TK);
    note("brk_dis", 4, 0);
    for (int i = 0; i < 3; i++) begin
      lower_limit_mode = 1'(i > 0);
      set_freq = (i < 2) ? 16'h01F4 : 16'h07D0;
      lower_limit_freq = 16'h03E8;
      go(3 * TK);
      note("low_f", 5, (i == 0) ? 16'h03E8 : (i == 1) ? 16'h0000 : 16'h07D0);
      note("low_s", 6, (i == 1) ? 1 : 0);
    end
    running = 1'h0;
    fan_mode_select = 2'h0;
    go(3 * TK);
    note("fan_pwr", 7, 1);
    fan_mode_select = 2'h2;
    for (int i = 0; i < 4; i++) begin
      heatsink_temp = tv[i];
      go(3 * TK);
      note("fan_tmp", 7, (i < 2) ? 1 : 0);
    end
    fan_mode_select = 2'h1;
    running = 1'h1;
    go(3 * TK);
    note("fan_run", 7, 1);
    running = 1'h0;
    param_setting = 1'h1;
    go(4 * TK);
    note("fan_hold", 7, 1);
    go(12 * TK);
    note("fan_stop", 7, 0);
    fset(16'h0BB9);
    note("pwm_off", 8, 0);
    pwm_segment_switch_enable = 1'h1;
    go(3 * TK);
    note("pwm_5", 8, 1);
    fset(16'h03E8);
    note("pwm_7", 8, 0);
    for (int i = 0; i < 7; i++) begin
      {terminal_ctrl, run_cmd, jog_cmd, jog_priority_enable} = jt[i][5:2];
      go(3);
      note("run_st", 9, jt[i][1:0]);
    end
    go(2);
    summarize();
  end
endmodule
